// file: core/mps_sequencer.sv
// Motion program sequencer: chains position sets and branches
// Function
// - Run linked steps one after another
// - Each step holds two successor indices
// - Branch input one/two picks successor one/two
// - Branch inputs are general inputs 2, 3
// - Terminating and circular chains both allowed
// - Two outputs, per-step message choice
// - Start from home, start with selector index, or bus
// - Stop input halts a running program
// - Per-step option ignores stop input
// - Immediate mode jumps on branch edge
// - Ignore mode takes successor one
// - Continue mode: single successor, unconditional
// - Deferred mode evaluates latest recorded edge
// - Start rising edge latches selector index
// - Four selector inputs encode sixteen sets
// - Deferred mode selectable per step
`timescale 1ns/1ps
`default_nettype none
module mps_sequencer (
	input wire logic clk,
	input wire logic rst,
	input wire logic [mps_pkg::ADDR_W-1:0] busAddr,
	input wire logic [mps_pkg::DATA_W-1:0] busWrData,
	input wire logic busWr,
	input wire logic busRd,
	output logic [mps_pkg::DATA_W-1:0] busRdData,
	input wire logic [mps_pkg::IDX_W-1:0] gpInput,
	input wire logic startIn,
	input wire logic homeIn,
	input wire logic stopIn,
	input wire logic targetReachedIn,
	input wire logic remainReachedIn,
	output logic stepGo,
	output logic stepAbort,
	output logic [mps_pkg::IDX_W-1:0] stepIndex,
	output logic [mps_pkg::OUT_N-1:0] digOut,
	output logic runningOut,
	output logic irq
);
	// ==========================================================
	// State type and registers
	typedef enum logic [1:0] {
		SEQ_IDLE,
		SEQ_LAUNCH,
		SEQ_MOVE
	} mps_state_type;

	mps_state_type stateFf;
	mps_state_type nxtState;
	logic [mps_pkg::IDX_W-1:0] idxFf;
	logic [mps_pkg::IDX_W-1:0] nxtIdx;
	mps_pkg::mps_rec_type recFf;
	mps_pkg::mps_rec_type nxtRec;
	logic prevAFf;
	logic prevBFf;
	logic prevStartFf;
	logic prevHomeFf;
	logic goFf;
	logic abortFf;
	logic [mps_pkg::OUT_N-1:0] outFf;
	logic runFf;
	logic irqFf;
	logic [mps_pkg::IRQ_W-1:0] irqStatFf;
	logic [mps_pkg::IRQ_W-1:0] irqEnFf;
	logic busGoFf;
	logic [mps_pkg::IDX_W-1:0] busIdxFf;
	logic [mps_pkg::DATA_W-1:0] rdDataFf;

	// ==========================================================
	// Step table
	mps_cfg_if cfgBus ();

	mps_step_table u_table (
		.clk(clk),
		.rst(rst),
		.cfg(cfgBus)
	);

	// ==========================================================
	// Register decode
	wire logic hitCtrl = busAddr == mps_pkg::REG_CTRL;
	wire logic hitStatus = busAddr == mps_pkg::REG_STATUS;
	wire logic hitIrqStat = busAddr == mps_pkg::REG_IRQ_STAT;
	wire logic hitIrqClr = busAddr == mps_pkg::REG_IRQ_CLR;
	wire logic hitIrqEn = busAddr == mps_pkg::REG_IRQ_EN;
	wire logic hitStep = (busAddr & mps_pkg::REG_STEP_MASK) == mps_pkg::REG_STEP_BASE;
	wire logic [mps_pkg::IDX_W-1:0] busStepIdx =
		busAddr[mps_pkg::STEP_IDX_LSB +: mps_pkg::IDX_W];
	wire logic wrCtrl = busWr && hitCtrl;
	wire logic wrIrqClr = busWr && hitIrqClr;
	wire logic wrIrqEn = busWr && hitIrqEn;

	// Step settings go straight into the table
	assign cfgBus.wrEn = busWr && hitStep;
	assign cfgBus.wrIdx = busStepIdx;
	assign cfgBus.wrData = busWrData[mps_pkg::CFG_W-1:0];
	assign cfgBus.rdIdx = busStepIdx;
	assign cfgBus.curIdx = idxFf;

	// ==========================================================
	// Fields of the running step
	wire logic [mps_pkg::CFG_W-1:0] cur = cfgBus.curCfg;
	wire logic [mps_pkg::IDX_W-1:0] next1Idx = cur[mps_pkg::CFG_NXT1_LSB +: mps_pkg::IDX_W];
	wire logic next1Vld = cur[mps_pkg::CFG_NXT1_VLD];
	wire logic [mps_pkg::IDX_W-1:0] next2Idx = cur[mps_pkg::CFG_NXT2_LSB +: mps_pkg::IDX_W];
	wire logic next2Vld = cur[mps_pkg::CFG_NXT2_VLD];
	wire mps_pkg::mps_mode_type curMode =
		mps_pkg::mps_mode_type'(cur[mps_pkg::CFG_MODE_LSB +: 2]);
	wire logic stopIgnore = cur[mps_pkg::CFG_STOP_IGN];
	wire mps_pkg::mps_msg_type msgSel0 =
		mps_pkg::mps_msg_type'(cur[mps_pkg::CFG_OUT0_LSB +: 2]);
	wire mps_pkg::mps_msg_type msgSel1 =
		mps_pkg::mps_msg_type'(cur[mps_pkg::CFG_OUT1_LSB +: 2]);

	// ==========================================================
	// Input conditioning
	// Branch signals come from general inputs 2 and 3
	wire logic branchSelA = gpInput[mps_pkg::DIN_BRANCH_A];
	wire logic branchSelB = gpInput[mps_pkg::DIN_BRANCH_B];
	// Edges are seen in the first cycle the input is high after a low sample
	wire logic edgeA = branchSelA && !prevAFf;
	wire logic edgeB = branchSelB && !prevBFf;
	wire logic startEdge = startIn && !prevStartFf;
	wire logic homeEdge = homeIn && !prevHomeFf;
	wire logic running = stateFf != SEQ_IDLE;
	wire logic moving = stateFf == SEQ_MOVE;

	// Previous levels for edge detection
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prevAFf <= 1'b0;
			prevBFf <= 1'b0;
			prevStartFf <= 1'b0;
			prevHomeFf <= 1'b0;
		end else begin
			prevAFf <= branchSelA;
			prevBFf <= branchSelB;
			prevStartFf <= startIn;
			prevHomeFf <= homeIn;
		end
	end

	// ==========================================================
	// Start sources, home wins over start, start over the bus
	wire logic anyStart = (homeEdge || startEdge || busGoFf) && !stopIn;
	wire logic [mps_pkg::IDX_W-1:0] startIdx =
		homeEdge ? mps_pkg::HOME_STEP :
		startEdge ? gpInput :
		busIdxFf;

	// Stop halts unless the step is marked to ride through it
	wire logic haltReq = running && stopIn && !stopIgnore;

	// ==========================================================
	// Successor choice at the end of a step
	logic pickB;
	always_comb begin
		pickB = 1'b0;
		unique case (curMode)
			mps_pkg::MODE_CONT: pickB = 1'b0;
			mps_pkg::MODE_IGNORE: pickB = 1'b0;
			// Level evaluation when the target comes first
			mps_pkg::MODE_IMMEDIATE: pickB = branchSelB && !branchSelA;
			mps_pkg::MODE_DEFERRED: pickB = recFf == mps_pkg::REC_B;
		endcase
	end

	wire logic [mps_pkg::IDX_W-1:0] succIdx = pickB ? next2Idx : next1Idx;
	wire logic succVld = pickB ? next2Vld : next1Vld;

	// Immediate mode aborts the step on a rising branch input
	wire logic immMode = curMode == mps_pkg::MODE_IMMEDIATE;
	wire logic immA = immMode && edgeA && next1Vld;
	wire logic immB = immMode && edgeB && next2Vld && !immA;
	wire logic immJump = moving && (immA || immB);
	wire logic [mps_pkg::IDX_W-1:0] immIdx = immA ? next1Idx : next2Idx;

	// ==========================================================
	// Sequencing
	logic evDone;
	logic evEnd;
	logic evHalt;
	logic launch;
	always_comb begin
		nxtState = stateFf;
		nxtIdx = idxFf;
		evDone = 1'b0;
		evEnd = 1'b0;
		evHalt = 1'b0;
		launch = 1'b0;
		if (haltReq) begin
			nxtState = SEQ_IDLE;
			evHalt = 1'b1;
		end else if (anyStart) begin
			nxtIdx = startIdx;
			nxtState = SEQ_LAUNCH;
			launch = 1'b1;
		end else begin
			unique case (stateFf)
				SEQ_IDLE: nxtState = SEQ_IDLE;
				SEQ_LAUNCH: nxtState = SEQ_MOVE;
				SEQ_MOVE: begin
					if (immJump) begin
						nxtIdx = immIdx;
						nxtState = SEQ_LAUNCH;
						launch = 1'b1;
					end else if (targetReachedIn) begin
						evDone = 1'b1;
						if (succVld) begin
							// A link back to an earlier step loops forever
							nxtIdx = succIdx;
							nxtState = SEQ_LAUNCH;
							launch = 1'b1;
						end else begin
							nxtState = SEQ_IDLE;
							evEnd = 1'b1;
						end
					end
				end
			endcase
		end
	end

	// Latest branch edge while the step moves; cleared per step
	always_comb begin
		nxtRec = recFf;
		if (launch || stateFf == SEQ_IDLE) begin
			nxtRec = mps_pkg::REC_NONE;
		end else if (edgeB) begin
			nxtRec = mps_pkg::REC_B;
		end else if (edgeA) begin
			nxtRec = mps_pkg::REC_A;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			stateFf <= SEQ_IDLE;
			idxFf <= mps_pkg::HOME_STEP;
			recFf <= mps_pkg::REC_NONE;
		end else begin
			stateFf <= nxtState;
			idxFf <= nxtIdx;
			recFf <= nxtRec;
		end
	end

	// ==========================================================
	// Handshake to the positioning controller
	// One-cycle pulses; the controller drops its reached flag on go
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			goFf <= 1'b0;
			abortFf <= 1'b0;
		end else begin
			goFf <= launch;
			abortFf <= evHalt;
		end
	end

	// ==========================================================
	// Message outputs, chosen per step
	logic [mps_pkg::OUT_N-1:0] msgLevel;
	mps_pkg::mps_msg_type msgSel [mps_pkg::OUT_N];
	assign msgSel[0] = msgSel0;
	assign msgSel[1] = msgSel1;

	genvar go;
	generate
		for (go = 0; go < mps_pkg::OUT_N; go++) begin : g_msg
			always_comb begin
				msgLevel[go] = 1'b0;
				unique case (msgSel[go])
					mps_pkg::MSG_TARGET: msgLevel[go] = targetReachedIn;
					mps_pkg::MSG_REMAIN: msgLevel[go] = remainReachedIn;
					mps_pkg::MSG_ACTIVE: msgLevel[go] = 1'b1;
					mps_pkg::MSG_OFF: msgLevel[go] = 1'b0;
				endcase
			end
		end
	endgenerate

	// Outputs rest low while no program runs, from the second idle cycle on; the first idle cycle keeps the last levels
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			outFf <= '0;
			runFf <= 1'b0;
		end else begin
			outFf <= running ? msgLevel : '0;
			runFf <= nxtState != SEQ_IDLE;
		end
	end

	// ==========================================================
	// Bus start request, taken once then dropped
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			busGoFf <= 1'b0;
			busIdxFf <= mps_pkg::HOME_STEP;
		end else if (wrCtrl) begin
			busGoFf <= busWrData[mps_pkg::CTRL_GO_BIT];
			busIdxFf <= busWrData[mps_pkg::CTRL_IDX_LSB +: mps_pkg::IDX_W];
		end else begin
			busGoFf <= 1'b0;
		end
	end

	// ==========================================================
	// Interrupts: sticky events, set beats a clear in the same cycle
	wire logic [mps_pkg::IRQ_W-1:0] irqEvents = {evHalt, evEnd, evDone};
	wire logic [mps_pkg::IRQ_W-1:0] irqClr =
		wrIrqClr ? busWrData[mps_pkg::IRQ_W-1:0] : '0;
	wire logic [mps_pkg::IRQ_W-1:0] nxtIrqStat = (irqStatFf & ~irqClr) | irqEvents;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irqStatFf <= '0;
			irqEnFf <= '0;
			irqFf <= 1'b0;
		end else begin
			irqStatFf <= nxtIrqStat;
			irqEnFf <= wrIrqEn ? busWrData[mps_pkg::IRQ_W-1:0] : irqEnFf;
			irqFf <= |(nxtIrqStat & (wrIrqEn ? busWrData[mps_pkg::IRQ_W-1:0] : irqEnFf));
		end
	end

	// ==========================================================
	// Read data, valid the cycle after the strobe only
	wire logic [mps_pkg::DATA_W-1:0] statusWord =
		(mps_pkg::DATA_W)'(runFf) << mps_pkg::STAT_RUN_BIT |
		(mps_pkg::DATA_W)'(idxFf) << mps_pkg::STAT_IDX_LSB |
		(mps_pkg::DATA_W)'(recFf) << mps_pkg::STAT_REC_LSB;
	wire logic [mps_pkg::DATA_W-1:0] ctrlWord =
		(mps_pkg::DATA_W)'(busIdxFf) << mps_pkg::CTRL_IDX_LSB;
	wire logic [mps_pkg::DATA_W-1:0] rdMux =
		hitCtrl ? ctrlWord :
		hitStatus ? statusWord :
		hitIrqStat ? (mps_pkg::DATA_W)'(irqStatFf) :
		hitIrqEn ? (mps_pkg::DATA_W)'(irqEnFf) :
		hitStep ? (mps_pkg::DATA_W)'(cfgBus.rdCfg) :
		'0;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdDataFf <= '0;
		end else begin
			rdDataFf <= busRd ? rdMux : '0;
		end
	end

	// ==========================================================
	// Port drive
	assign busRdData = rdDataFf;
	assign stepGo = goFf;
	assign stepAbort = abortFf;
	assign stepIndex = idxFf;
	assign digOut = outFf;
	assign runningOut = runFf;
	assign irq = irqFf;
endmodule // mps_sequencer
`default_nettype wire

// file: core/mps_step_table.sv
// Flip-flop table of per-step motion program settings
`timescale 1ns/1ps
`default_nettype none
module mps_step_table (
	input wire logic clk,
	input wire logic rst,
	mps_cfg_if.table_side cfg
);
	// ==========================================================
	// Storage, one word per position set
	logic [mps_pkg::CFG_W-1:0] entryFf [mps_pkg::STEPS];

	genvar gi;
	generate
		for (gi = 0; gi < mps_pkg::STEPS; gi++) begin : g_entry
			// Write when the slot index matches
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					entryFf[gi] <= mps_pkg::CFG_RESET;
				end else if (cfg.wrEn && cfg.wrIdx == (mps_pkg::IDX_W)'(gi)) begin
					entryFf[gi] <= cfg.wrData;
				end
			end
		end
	endgenerate

	// Two read ports: running step and software readback
	assign cfg.curCfg = entryFf[cfg.curIdx];
	assign cfg.rdCfg = entryFf[cfg.rdIdx];
endmodule // mps_step_table
`default_nettype wire

// file: shared/mps_cfg_if.sv
// Connection between the sequencer and its step table
`timescale 1ns/1ps
`default_nettype none
interface mps_cfg_if;
	logic wrEn;
	logic [mps_pkg::IDX_W-1:0] wrIdx;
	logic [mps_pkg::CFG_W-1:0] wrData;
	logic [mps_pkg::IDX_W-1:0] curIdx;
	logic [mps_pkg::CFG_W-1:0] curCfg;
	logic [mps_pkg::IDX_W-1:0] rdIdx;
	logic [mps_pkg::CFG_W-1:0] rdCfg;

	modport table_side (
		input wrEn, wrIdx, wrData, curIdx, rdIdx,
		output curCfg, rdCfg
	);
	modport seq_side (
		output wrEn, wrIdx, wrData, curIdx, rdIdx,
		input curCfg, rdCfg
	);
endinterface
`default_nettype wire

// file: shared/mps_pkg.sv
// Shared constants and types of the motion program sequencer
`default_nettype none
package mps_pkg;
	// ==========================================================
	// Sizes
	localparam int STEPS = 16;
	localparam int IDX_W = 4;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int CFG_W = 17;
	localparam int IRQ_W = 3;
	localparam int OUT_N = 2;

	// ==========================================================
	// Register offsets (byte addresses)
	localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
	localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 8'h08;
	localparam logic [ADDR_W-1:0] REG_IRQ_CLR = 8'h0C;
	localparam logic [ADDR_W-1:0] REG_IRQ_EN = 8'h10;
	localparam logic [ADDR_W-1:0] REG_STEP_BASE = 8'h40;
	localparam logic [ADDR_W-1:0] REG_STEP_MASK = 8'hC3;
	localparam int STEP_IDX_LSB = 2;

	// ==========================================================
	// Control and status fields
	localparam int CTRL_GO_BIT = 0;
	localparam int CTRL_IDX_LSB = 4;
	localparam int STAT_RUN_BIT = 0;
	localparam int STAT_IDX_LSB = 4;
	localparam int STAT_REC_LSB = 8;

	// ==========================================================
	// Step configuration word layout
	localparam int CFG_NXT1_LSB = 0;
	localparam int CFG_NXT1_VLD = 4;
	localparam int CFG_NXT2_LSB = 5;
	localparam int CFG_NXT2_VLD = 9;
	localparam int CFG_MODE_LSB = 10;
	localparam int CFG_STOP_IGN = 12;
	localparam int CFG_OUT0_LSB = 13;
	localparam int CFG_OUT1_LSB = 15;
	localparam logic [CFG_W-1:0] CFG_RESET = 17'h00000;

	// ==========================================================
	// Input pin positions and fixed entry step
	localparam int DIN_BRANCH_A = 2;
	localparam int DIN_BRANCH_B = 3;
	localparam logic [IDX_W-1:0] HOME_STEP = 4'h0;

	// ==========================================================
	// Interrupt bits
	localparam int IRQ_DONE = 0;
	localparam int IRQ_END = 1;
	localparam int IRQ_HALT = 2;

	// ==========================================================
	// Enumerations
	typedef enum logic [1:0] {
		MODE_CONT,
		MODE_IGNORE,
		MODE_IMMEDIATE,
		MODE_DEFERRED
	} mps_mode_type;

	typedef enum logic [1:0] {
		MSG_TARGET,
		MSG_REMAIN,
		MSG_ACTIVE,
		MSG_OFF
	} mps_msg_type;

	typedef enum logic [1:0] {
		REC_NONE,
		REC_A,
		REC_B
	} mps_rec_type;
endpackage
`default_nettype wire

// file: tb/mps_ctrl_model.sv
// Behavioural positioning controller behind the sequencer
`timescale 1ns/1ps
`default_nettype none
module mps_ctrl_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic stepGo,
	input wire logic stepAbort,
	input wire logic runningOut,
	input wire logic [7:0] travel,
	output logic targetReachedIn,
	output logic remainReachedIn
);
	logic [7:0] cnt_ff;

	// ==========================================================
	// Travel timer: reload on launch, target as a one-cycle pulse
	// Pulse keeps the reached level away from the next launch cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_ff <= 8'h00;
			targetReachedIn <= 1'b0;
			remainReachedIn <= 1'b0;
		end else begin
			targetReachedIn <= 1'b0;
			if (stepGo)
				cnt_ff <= travel;
			else if (stepAbort || !runningOut)
				cnt_ff <= 8'h00;
			else if (cnt_ff != 8'h00)
				cnt_ff <= cnt_ff - 8'h01;
			if (cnt_ff == 8'h01 && runningOut && !stepGo)
				targetReachedIn <= 1'b1;
			remainReachedIn <= (cnt_ff != 8'h00) && (cnt_ff < 8'h04);
		end
	end
endmodule // mps_ctrl_model
`default_nettype wire

// file: tb/mps_seq_sva.sv
// Port-level checker for the motion program sequencer
`timescale 1ns/1ps
`default_nettype none
module mps_seq_sva (
	input wire logic clk,
	input wire logic rst,
	input wire logic [mps_pkg::ADDR_W-1:0] busAddr,
	input wire logic [mps_pkg::DATA_W-1:0] busWrData,
	input wire logic busWr,
	input wire logic busRd,
	input wire logic [mps_pkg::DATA_W-1:0] busRdData,
	input wire logic [mps_pkg::IDX_W-1:0] gpInput,
	input wire logic startIn,
	input wire logic homeIn,
	input wire logic stopIn,
	input wire logic targetReachedIn,
	input wire logic remainReachedIn,
	input wire logic stepGo,
	input wire logic stepAbort,
	input wire logic [mps_pkg::IDX_W-1:0] stepIndex,
	input wire logic [mps_pkg::OUT_N-1:0] digOut,
	input wire logic runningOut,
	input wire logic irq
);
	// ==========================================================
	// Launch sequences
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_startEdge;
		$rose(startIn) && !homeIn && !stopIn;
	endsequence
	sequence s_homeEdge;
		$rose(homeIn) && !stopIn;
	endsequence
	sequence s_launch;
		stepGo && runningOut;
	endsequence

	// ==========================================================
	// Properties
	a_start_latch: assert property (s_startEdge |=> s_launch ##0 stepIndex == $past(gpInput))
		else $error("start edge did not launch the selected step");
	a_home_entry: assert property (s_homeEdge |=> s_launch ##0 stepIndex == mps_pkg::HOME_STEP)
		else $error("home edge did not launch the entry step");
	a_go_single: assert property (stepGo |=> !stepGo)
		else $error("step launch pulse longer than one cycle");
	a_go_running: assert property (stepGo |-> runningOut)
		else $error("step launched while idle");
	a_abort_cause: assert property (stepAbort |->
		$past(stopIn) && $past(runningOut) && !runningOut)
		else $error("halt without stop input or program still running");
	a_stop_blocks: assert property (stopIn && !runningOut |=> !stepGo && !runningOut)
		else $error("program started while stop input high");
	a_idle_quiet: assert property (!runningOut && !$past(runningOut) |-> digOut == '0)
		else $error("message outputs active while idle");
	a_read_window: assert property (!$past(busRd) |-> busRdData == '0)
		else $error("read data outside its cycle");
	a_index_hold: assert property (runningOut && !stepGo |-> $stable(stepIndex))
		else $error("step index changed without a launch");
	c_abort_seen: cover property (stepAbort);
endmodule // mps_seq_sva

bind mps_sequencer mps_seq_sva chk_u (.clk, .rst, .busAddr, .busWrData, .busWr, .busRd,
	.busRdData, .gpInput, .startIn, .homeIn, .stopIn, .targetReachedIn, .remainReachedIn,
	.stepGo, .stepAbort, .stepIndex, .digOut, .runningOut, .irq);
`default_nettype wire

// file: tb/mps_sequencer_bench.sv
// Self-checking bench for the motion program sequencer
`timescale 1ns/1ps
`default_nettype none
module mps_sequencer_bench;
	logic clk = 1'b0;
	logic rst, busWr, busRd, startIn, homeIn, stopIn, stepGo, stepAbort, runningOut, irq;
	logic targetReachedIn, remainReachedIn;
	logic [7:0] busAddr, travel;
	logic [31:0] busWrData, busRdData;
	logic [3:0] gpInput, stepIndex;
	logic [1:0] digOut;
	int errors, comparisons;

	// ==========================================================
	// Clock, design and controller model
	always #20 clk = ~clk;
	mps_sequencer dut_u (.clk, .rst, .busAddr, .busWrData, .busWr, .busRd, .busRdData,
		.gpInput, .startIn, .homeIn, .stopIn, .targetReachedIn, .remainReachedIn,
		.stepGo, .stepAbort, .stepIndex, .digOut, .runningOut, .irq);
	mps_ctrl_model ctl_u (.clk, .rst, .stepGo, .stepAbort, .runningOut, .travel,
		.targetReachedIn, .remainReachedIn);

	// ==========================================================
	// Tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		busAddr <= a;
		busWrData <= d;
		busWr <= 1'b1;
		@(posedge clk);
		busWr <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		busAddr <= a;
		busRd <= 1'b1;
		@(posedge clk);
		busRd <= 1'b0;
		#1 chk(busRdData, exp);
	endtask
	function automatic logic [7:0] sa(input logic [3:0] i);
		return mps_pkg::REG_STEP_BASE + {2'b00, i, 2'b00};
	endfunction
	// Step word: successors, mode, stop option, two message choices
	function automatic logic [31:0] cw(input logic [3:0] n1, input logic v1, input logic [3:0] n2,
		input logic v2, input logic [1:0] md, input logic ig, input logic [1:0] o0,
		input logic [1:0] o1);
		return {15'h0000, o1, o0, ig, md, v2, n2, v1, n1};
	endfunction
	task automatic go(input logic [3:0] idx, input int lim);
		int n;
		n = 0;
		// Step off the edge so a pulse launched on it is already visible
		#1;
		while (stepGo !== 1'b1 && n < lim) begin
			@(posedge clk);
			#1 n++;
		end
		chk({31'h0, n < lim}, 32'h1);
		chk({28'h0, stepIndex}, {28'h0, idx});
		@(posedge clk);
		#1;
	endtask
	task automatic waitIdle(input int lim);
		int n;
		n = 0;
		while (runningOut !== 1'b0 && n < lim) begin
			@(posedge clk);
			#1 n++;
		end
		chk({31'h0, runningOut}, 32'h0);
	endtask
	task automatic startAt(input logic [3:0] idx);
		@(posedge clk);
		gpInput <= idx;
		@(posedge clk);
		startIn <= 1'b1;
		@(posedge clk);
		startIn <= 1'b0;
	endtask
	task complete_run;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// ==========================================================
	// Watchdog, far beyond the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		complete_run;
	end

	// ==========================================================
	// Test sequence
	initial begin
		rst = 1'b1;
		{busWr, busRd, startIn, homeIn, stopIn} = 5'h00;
		busAddr = 8'h00;
		busWrData = 32'h0;
		gpInput = 4'h0;
		travel = 8'h0C;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		rdc(mps_pkg::REG_STATUS, 32'h0);
		rdc(sa(4'h3), 32'h0);
		wr(sa(4'h3), 32'hFFFFFFFF);
		rdc(sa(4'h3), 32'h0001FFFF);
		wr(sa(4'h3), 32'h0);
		wr(8'h20, 32'h1);
		rdc(8'h20, 32'h0);
		wr(mps_pkg::REG_IRQ_EN, 32'h7);
		rdc(mps_pkg::REG_IRQ_EN, 32'h7);
		$display("registers done");
		// Linear chain 5 -> 7 -> end, started from the selector
		wr(sa(4'h5), cw(4'h7, 1'b1, 4'h0, 1'b0, mps_pkg::MODE_CONT, 1'b0, mps_pkg::MSG_ACTIVE,
			mps_pkg::MSG_OFF));
		startAt(4'h5);
		go(4'h5, 4);
		#80 chk({30'h0, digOut}, 32'h1);
		go(4'h7, 40);
		waitIdle(40);
		chk({30'h0, digOut}, 32'h3);
		rdc(mps_pkg::REG_IRQ_STAT, 32'h3);
		chk({31'h0, irq}, 32'h1);
		wr(mps_pkg::REG_IRQ_CLR, 32'h7);
		rdc(mps_pkg::REG_IRQ_STAT, 32'h0);
		chk({31'h0, irq}, 32'h0);
		@(posedge clk);
		homeIn <= 1'b1;
		@(posedge clk);
		homeIn <= 1'b0;
		go(mps_pkg::HOME_STEP, 4);
		waitIdle(40);
		$display("chain done");
		// Ignore mode with branch B held high, started by bus
		wr(sa(4'h2), cw(4'h4, 1'b1, 4'h9, 1'b1, mps_pkg::MODE_IGNORE, 1'b0, 2'h3, 2'h3));
		gpInput <= 4'h8;
		wr(mps_pkg::REG_CTRL, 32'h21);
		go(4'h2, 4);
		go(4'h4, 40);
		waitIdle(40);
		// Immediate mode: branch B edge jumps before target
		wr(sa(4'h1), cw(4'h3, 1'b1, 4'h6, 1'b1, mps_pkg::MODE_IMMEDIATE, 1'b0, 2'h3, 2'h3));
		travel <= 8'h3C;
		gpInput <= 4'h0;
		wr(mps_pkg::REG_CTRL, 32'h11);
		go(4'h1, 4);
		@(posedge clk);
		gpInput <= 4'h8;
		go(4'h6, 6);
		waitIdle(80);
		// Deferred mode: A edge then B edge, latest one decides
		wr(sa(4'h8), cw(4'h6, 1'b1, 4'h9, 1'b1, mps_pkg::MODE_DEFERRED, 1'b0, 2'h3, 2'h3));
		gpInput <= 4'h0;
		wr(mps_pkg::REG_CTRL, 32'h81);
		go(4'h8, 4);
		@(posedge clk);
		gpInput <= 4'h4;
		repeat (2) @(posedge clk);
		gpInput <= 4'h0;
		repeat (2) @(posedge clk);
		gpInput <= 4'h8;
		repeat (2) @(posedge clk);
		gpInput <= 4'h0;
		rdc(mps_pkg::REG_STATUS, 32'h281);
		go(4'h9, 80);
		waitIdle(80);
		$display("branching done");
		// Circular 10 <-> 11, stop ignored on 10 only
		travel <= 8'h0C;
		wr(sa(4'hA), cw(4'hB, 1'b1, 4'h0, 1'b0, mps_pkg::MODE_CONT, 1'b1, 2'h3, 2'h3));
		wr(sa(4'hB), cw(4'hA, 1'b1, 4'h0, 1'b0, mps_pkg::MODE_CONT, 1'b0, 2'h3, 2'h3));
		wr(mps_pkg::REG_IRQ_CLR, 32'h7);
		startAt(4'hA);
		go(4'hA, 4);
		go(4'hB, 40);
		go(4'hA, 40);
		@(posedge clk);
		stopIn <= 1'b1;
		go(4'hB, 40);
		chk({31'h0, stepAbort}, 32'h1);
		waitIdle(10);
		rdc(mps_pkg::REG_IRQ_STAT, 32'h5);
		wr(mps_pkg::REG_IRQ_EN, 32'h2);
		repeat (2) @(posedge clk);
		#1 chk({31'h0, irq}, 32'h0);
		wr(mps_pkg::REG_IRQ_EN, 32'h4);
		repeat (2) @(posedge clk);
		#1 chk({31'h0, irq}, 32'h1);
		startAt(4'h3);
		repeat (4) @(posedge clk);
		#1 chk({31'h0, runningOut}, 32'h0);
		@(posedge clk);
		stopIn <= 1'b0;
		$display("stop done");
		complete_run;
	end
endmodule // mps_sequencer_bench
`default_nettype wire
